//--- pmr_consts.svh
/*
  Holds the register addresses, control field positions and fixed read values
  of the management register block.
  Assumes inclusion by bare name from the design module.
*/
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

`define PMR_REG_CONTROL     5'h00
`define PMR_REG_STATUS      5'h01
`define PMR_REG_IDENT_HI    5'h02
`define PMR_REG_IDENT_LO    5'h03
`define PMR_REG_ADVERTISE   5'h04
`define PMR_REG_PARTNER     5'h05
`define PMR_REG_EXPANSION   5'h06
`define PMR_REG_NP_TX       5'h07
`define PMR_REG_NP_RX       5'h08
`define PMR_REG_EXT_STATUS  5'h0F
`define PMR_REG_AN_IRQ      5'h10
`define PMR_REG_LOOPBACK    5'h11

`define PMR_BIT_RESET       15
`define PMR_BIT_LOOPBACK    14
`define PMR_BIT_SPEED_LSB   13
`define PMR_BIT_AN_ENABLE   12
`define PMR_BIT_POWER_DOWN  11
`define PMR_BIT_ISOLATE     10
`define PMR_BIT_AN_RESTART  9
`define PMR_BIT_DUPLEX      8
`define PMR_BIT_COL_TEST    7
`define PMR_BIT_SPEED_MSB   6
`define PMR_BIT_ONE_WAY_TX  5

`define PMR_BROADCAST_ADDR  5'h00
`define PMR_OP_WRITE        2'h1
`define PMR_OP_READ         2'h2
`define PMR_START_CODE      2'h1
`define PMR_STATUS_VALUE    16'h01C8
`define PMR_ADVERTISE_INIT  16'h01A0
`define PMR_EXT_STATUS_VAL  16'h8000

`endif

//--- pmr_mdio_master.sv
/*
  Holds a behavioural station-management master facing the register block.
  Assumes the data line has a pull-up and the slave drives it only with its enable high.
*/
`timescale 1ns/1ps

module pmr_mdio_master (
  output logic      mdc_out,
  output logic      line_out,
  input  wire logic slave_oe_in,
  input  wire logic slave_data_in
);
  logic drv_en;
  logic drv_bit;

  // Wire level from both drivers; the pull-up wins when nobody drives.
  assign line_out = slave_oe_in ? slave_data_in : (drv_en ? drv_bit : 1'b1);

  initial begin
    mdc_out = 1'b0; // Clock stands still until a frame or idle run.
    drv_en = 1'b0;
    drv_bit = 1'b1;
  end

  // Clock edges with the line released.
  task automatic idle(input int n);
    drv_en = 1'b0;
    repeat (n) begin
      #8 mdc_out = 1'b1;
      #16 mdc_out = 1'b0;
      #8;
    end
  endtask

  // One whole frame, then two released bit times of idle ones.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
                       input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, 2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int s = 0; s < 64; s++) begin
      drv_en = !(op == 2'h2 && s >= 46); // Release for turnaround and read data.
      drv_bit = bits[63 - s];
      #8;
      if (s >= 48) rd = {rd[14:0], line_out};
      mdc_out = 1'b1;
      #16 mdc_out = 1'b0;
      #8;
    end
    idle(2);
  endtask
endmodule // pmr_mdio_master

//--- pmr_mdio_regs.sv
/*
  Holds the management-link slave and register file of the 1000BASE-X sublayer.
  Assumes the outside master drives the management clock and data, that the data
  line is resolved outside from the output enable, and that link status comes from
  sublayer logic on clk_in.
*/
`timescale 1ns/1ps
`include "pmr_consts.svh"

module pmr_mdio_regs #(
  parameter bit sublayer_reset_init_attr   = 1'b0,
  parameter bit loopback_init_attr         = 1'b0,
  parameter bit autoneg_enable_init_attr   = 1'b1,
  parameter bit power_down_init_attr       = 1'b0,
  parameter bit isolate_init_attr          = 1'b0,
  parameter bit one_way_tx_init_attr       = 1'b0,
  parameter bit ignore_broadcast_addr_attr = 1'b0,
  parameter logic [15:0] ident_high_value  = 16'h1234,  // Arbitrary identity value.
  parameter logic [15:0] ident_low_value   = 16'h5670   // Arbitrary identity value.
) (
  input  wire logic               clk_in,
  input  wire logic               rst_n_in,
  input  wire logic               mgmt_clock_in,
  input  wire logic               mdio_data_in,
  output logic                    mdio_data_out,
  output logic                    mdio_oe_out,
  input  wire logic [4:0]         slave_phys_addr_in,
  input  wire logic               link_up_in,
  input  wire logic               autoneg_done_in,
  output pmr_pkg::pmr_ctrl_t      ctrl_out,
  output logic                    sublayer_reset_out,
  output logic                    autoneg_restart_out
);
  import pmr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: frame shifter on the master's clock.
  // Everything in this section runs only while the master toggles its clock. The
  // master may stop the clock between frames, so no state here may depend on
  // free-running edges: a frame is finished on its own last edge, and the write
  // it carries is handed over by a toggle that the system side picks up later.

  // Two-flop synchronisers for the link-domain reset and status bits.
  // The reset reaches the link side two link clocks late, so the master must give
  // a few clock edges while reset is held and after it is released.
  logic       lrst_meta_reg, lrst_n_reg;
  logic [1:0] lstat_meta_reg, lstat_reg;

  always_ff @(posedge mgmt_clock_in) begin
    lrst_meta_reg <= rst_n_in;
    lrst_n_reg    <= lrst_meta_reg;
  end

  always_ff @(posedge mgmt_clock_in) begin
    lstat_meta_reg <= {link_up_in, autoneg_done_in};
    lstat_reg      <= lstat_meta_reg;
  end

  pmr_phase_t  phase_reg;
  logic [5:0]  bit_cnt_reg;
  logic [13:0] hdr_reg;
  logic [15:0] shift_reg;
  logic        pre_reg;
  logic        hit_reg;
  logic        wr_toggle_reg;
  pmr_write_t  wr_hold_reg;
  logic        drive_reg;
  logic        dout_reg;

  // Link-domain view of the registers, held from the crossing below.
  logic [15:0] ctrl_shadow_meta_reg, ctrl_shadow_reg;
  logic [15:0] lp_shadow_meta_reg, lp_shadow_reg;

  // Address match against own address or broadcast.
  function automatic logic addr_hit(input logic [4:0] phy, input logic [4:0] own);
    addr_hit = (phy == own) ||
               (!ignore_broadcast_addr_attr && phy == `PMR_BROADCAST_ADDR);
  endfunction

  // Unused addresses, the link-partner, expansion and next-page registers and the interrupt
  // control register read as zero; the identity words are arbitrary values.
  // Read-data decode of the register map.
  function automatic logic [15:0] read_word(input logic [4:0] ra, input logic [15:0] ctl,
                                            input logic [1:0] st, input logic [15:0] lb);
    unique case (ra)
      `PMR_REG_CONTROL:    read_word = ctl;
      // Status shows link up in bit 2 and negotiation done in bit 5.
      `PMR_REG_STATUS:     read_word = `PMR_STATUS_VALUE | {10'h000, st[0], 2'h0, st[1], 2'h0};
      `PMR_REG_IDENT_HI:   read_word = ident_high_value;
      `PMR_REG_IDENT_LO:   read_word = ident_low_value;
      `PMR_REG_ADVERTISE:  read_word = `PMR_ADVERTISE_INIT;
      `PMR_REG_EXT_STATUS: read_word = `PMR_EXT_STATUS_VAL;
      `PMR_REG_LOOPBACK:   read_word = lb;
      default:             read_word = 16'h0000;
    endcase
  endfunction

  // Frame walk: preamble, start, op, addresses, turnaround, data.
  // Edge by edge, counting from the edge that samples the first start bit (0):
  //   edges 1 to 13 shift the second start bit, op, device and register address;
  //   edge 14 is the first turnaround bit, where a read loads its word and the
  //   slave starts driving a zero for the second turnaround bit;
  //   edge 15 puts the most significant data bit on the line;
  //   edges 16 to 31 either shift the data out or shift a written word in.
  // A frame that is not for this device still walks all the way to its end, so
  // that its data bits are never taken for a new start code.
  always_ff @(posedge mgmt_clock_in) begin
    if (!lrst_n_reg) begin
      phase_reg     <= PMR_IDLE;
      bit_cnt_reg   <= 6'h00;
      hdr_reg       <= 14'h0000;
      shift_reg     <= 16'h0000;
      pre_reg       <= 1'b0;
      hit_reg       <= 1'b0;
      wr_toggle_reg <= 1'b0;
      wr_hold_reg   <= '0;
      drive_reg     <= 1'b0;
      dout_reg      <= 1'b1;
    end else begin
      pre_reg <= mdio_data_in;
      unique case (phase_reg)
        PMR_IDLE: begin
          drive_reg <= 1'b0;
          // A zero after a one is the first start bit.
          if (!mdio_data_in && pre_reg) begin
            phase_reg   <= PMR_HEADER;
            bit_cnt_reg <= 6'h00;
            hdr_reg     <= 14'h0000;
          end
        end
        PMR_HEADER: begin
          hdr_reg     <= {hdr_reg[12:0], mdio_data_in};
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
          if (bit_cnt_reg == 6'h0C) begin
            phase_reg   <= PMR_TURN;
            bit_cnt_reg <= 6'h00;
            // The header is one bit short here: second start bit at 11, device at 8:4.
            hit_reg     <= hdr_reg[11] && addr_hit(hdr_reg[8:4], slave_phys_addr_in);
          end
        end
        PMR_TURN: begin
          // Start code 01: hdr_reg[13:12] holds a zero and the second start bit; op is in hdr_reg[11:10].
          if (hdr_reg[13:12] == 2'h1 && hdr_reg[11:10] == 2'h0 && hit_reg
              && {hdr_reg[13], hdr_reg[12]} == `PMR_START_CODE) begin
            phase_reg <= PMR_IDLE;
          end
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
          // A read drives the line from the second turnaround bit to the last data bit.
          if (hit_reg && hdr_reg[11:10] == `PMR_OP_READ) begin
            drive_reg <= 1'b1;
            if (bit_cnt_reg == 6'h00) begin
              dout_reg  <= 1'b0;
              shift_reg <= read_word(hdr_reg[4:0], ctrl_shadow_reg, lstat_reg, lp_shadow_reg);
            end else begin
              phase_reg   <= PMR_DATA_OUT;
              bit_cnt_reg <= 6'h00;
              dout_reg    <= shift_reg[15];
              shift_reg   <= {shift_reg[14:0], 1'b0};
            end
          end else if (bit_cnt_reg == 6'h01) begin
            phase_reg   <= PMR_DATA_IN;
            bit_cnt_reg <= 6'h00;
          end
        end
        PMR_DATA_OUT: begin
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
          dout_reg    <= shift_reg[15];
          shift_reg   <= {shift_reg[14:0], 1'b0};
          if (bit_cnt_reg == 6'h0F) begin
            phase_reg <= PMR_IDLE;
            drive_reg <= 1'b0;
            dout_reg  <= 1'b1;
          end
        end
        PMR_DATA_IN: begin
          bit_cnt_reg <= bit_cnt_reg + 6'h01;
          shift_reg   <= {shift_reg[14:0], mdio_data_in};
          if (bit_cnt_reg == 6'h0F) begin
            phase_reg <= PMR_IDLE;
            if (hit_reg && hdr_reg[11:10] == `PMR_OP_WRITE) begin
              wr_hold_reg   <= '{addr: hdr_reg[4:0], data: {shift_reg[14:0], mdio_data_in}};
              wr_toggle_reg <= ~wr_toggle_reg;
            end
          end
        end
        default: phase_reg <= PMR_IDLE;
      endcase
    end
  end

  // The data line idles high so a released bit reads as the pull-up level.
  // Link outputs come straight from flops; clock output is not provided.
  assign mdio_oe_out   = drive_reg;
  assign mdio_data_out = dout_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Crossing: write toggle to clk_in, register views back to the link.
  // A finished write flips one toggle bit; the held address and data word do not
  // change again until the next write, which is at least a whole frame later, so
  // the system side may read the word without its own synchroniser once the
  // toggle has passed two flops. Two writes closer than four system clocks apart
  // would be merged, which a master at a legal link rate can never produce.

  logic       wt_meta_reg, wt_sync_reg, wt_seen_reg;
  logic       wr_pulse;
  pmr_write_t wr_take;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wt_meta_reg <= 1'b0;
      wt_sync_reg <= 1'b0;
      wt_seen_reg <= 1'b0;
    end else begin
      wt_meta_reg <= wr_toggle_reg;
      wt_sync_reg <= wt_meta_reg;
      wt_seen_reg <= wt_sync_reg;
    end
  end

  // Held write word is stable for many clk_in cycles once the toggle lands.
  assign wr_pulse = wt_sync_reg ^ wt_seen_reg;
  assign wr_take  = wr_hold_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Register file on clk_in.

  logic        reset_bit_reg, loopback_reg, an_en_reg, pdown_reg, isolate_reg;
  logic        restart_reg, one_way_reg;
  logic [15:0] loopback_ctl_reg, ctrl_word;
  logic        ctl_wr;

  assign ctl_wr = wr_pulse && wr_take.addr == `PMR_REG_CONTROL;

  // The reload has priority over a write in the same cycle: the reset bit is a
  // one-cycle strobe, and a write landing under it is lost just as it would be
  // inside a sublayer that is being reset. Power down is set by a write, or by the reload when
  // power_down_init_attr is set; writing zero to it leaves it alone, so the reload is its only clear.
  // Read/write control bits, reloaded by the sublayer reset bit.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || reset_bit_reg) begin
      loopback_reg <= loopback_init_attr;
      an_en_reg    <= autoneg_enable_init_attr;
      pdown_reg    <= power_down_init_attr;
      isolate_reg  <= isolate_init_attr;
      one_way_reg  <= one_way_tx_init_attr;
    end else if (ctl_wr) begin
      loopback_reg <= wr_take.data[`PMR_BIT_LOOPBACK];
      an_en_reg    <= wr_take.data[`PMR_BIT_AN_ENABLE];
      pdown_reg    <= pdown_reg | wr_take.data[`PMR_BIT_POWER_DOWN];
      isolate_reg  <= wr_take.data[`PMR_BIT_ISOLATE];
      one_way_reg  <= wr_take.data[`PMR_BIT_ONE_WAY_TX];
    end
  end

  // Self-clearing reset and restart: held one cycle, then back to zero.
  // Both strobes come from the write itself, so a later read of the control word
  // shows zero again without any software action.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      reset_bit_reg <= sublayer_reset_init_attr;
      restart_reg   <= 1'b0;
    end else begin
      reset_bit_reg <= ctl_wr && wr_take.data[`PMR_BIT_RESET];
      restart_reg   <= ctl_wr && wr_take.data[`PMR_BIT_AN_RESTART];
    end
  end

  // Vendor loopback control register.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in || reset_bit_reg) begin
      loopback_ctl_reg <= 16'h0000;
    end else if (wr_pulse && wr_take.addr == `PMR_REG_LOOPBACK) begin
      loopback_ctl_reg <= wr_take.data;
    end
  end

  // Control word as read: fixed bits and reserved zeros.
  always_comb begin
    ctrl_word                     = 16'h0000;
    ctrl_word[`PMR_BIT_RESET]     = reset_bit_reg;
    ctrl_word[`PMR_BIT_LOOPBACK]  = loopback_reg;
    ctrl_word[`PMR_BIT_SPEED_LSB] = 1'b0;
    ctrl_word[`PMR_BIT_AN_ENABLE] = an_en_reg;
    ctrl_word[`PMR_BIT_POWER_DOWN] = pdown_reg;
    ctrl_word[`PMR_BIT_ISOLATE]   = isolate_reg;
    ctrl_word[`PMR_BIT_AN_RESTART] = restart_reg;
    ctrl_word[`PMR_BIT_DUPLEX]    = 1'b1;
    ctrl_word[`PMR_BIT_COL_TEST]  = 1'b0;
    ctrl_word[`PMR_BIT_SPEED_MSB] = 1'b1;
    ctrl_word[`PMR_BIT_ONE_WAY_TX] = one_way_reg;
  end

  // Quasi-static register views pass through two flops into the link domain.
  // The views change only after a write or the reload that a write triggers, and a read takes its
  // word one whole frame after any earlier write has landed, so a word caught in
  // the middle of a change is never returned; it may be a few link clocks stale.
  always_ff @(posedge mgmt_clock_in) begin
    ctrl_shadow_meta_reg <= ctrl_word;
    ctrl_shadow_reg      <= ctrl_shadow_meta_reg;
    lp_shadow_meta_reg   <= loopback_ctl_reg;
    lp_shadow_reg        <= lp_shadow_meta_reg;
  end

  // The sublayer sees the control levels one cycle after the register file, and
  // the two strobes one cycle after they are set, each for exactly one cycle.
  // Outputs toward the sublayer, each from a flop.
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_out            <= '0;
      sublayer_reset_out  <= 1'b0;
      autoneg_restart_out <= 1'b0;
    end else begin
      ctrl_out            <= '{loopback: loopback_reg, autoneg_enable: an_en_reg,
                               power_down: pdown_reg, isolate: isolate_reg,
                               one_way_tx: one_way_reg};
      sublayer_reset_out  <= reset_bit_reg;
      autoneg_restart_out <= restart_reg;
    end
  end

endmodule // pmr_mdio_regs

//--- pmr_mdio_regs_bench.sv
/*
  Holds the self-checking bench of the management register block.
  Assumes the master model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps

module pmr_mdio_regs_bench;
  import pmr_pkg::*;
  localparam logic [4:0] own_addr = 5'h05;
  // Address and expected value; identity words are the design's arbitrary defaults.
  localparam logic [20:0] dec_tab [10] = '{21'h001140, 21'h0101EC, 21'h021234, 21'h035670,
    21'h0401A0, 21'h050000, 21'h060000, 21'h080000, 21'h0F8000, 21'h100000};
  logic       clk_in;
  logic       rst_n_in;
  logic       mdc;
  logic       line;
  logic       data_out;
  logic       oe;
  logic       link_up_in;
  logic       autoneg_done_in;
  logic [4:0] slave_phys_addr_in;
  pmr_ctrl_t  ctrl_out;
  logic       sublayer_reset_out;
  logic       autoneg_restart_out;
  int         miscompares = 0;
  int         checks = 0;
  int         n_reset = 0;
  int         n_restart = 0;

  pmr_mdio_regs pmr_mdio_regs_i (.clk_in(clk_in), .rst_n_in(rst_n_in), .mgmt_clock_in(mdc),
    .mdio_data_in(line), .mdio_data_out(data_out), .mdio_oe_out(oe),
    .slave_phys_addr_in(slave_phys_addr_in), .link_up_in(link_up_in),
    .autoneg_done_in(autoneg_done_in), .ctrl_out(ctrl_out),
    .sublayer_reset_out(sublayer_reset_out), .autoneg_restart_out(autoneg_restart_out));
  pmr_mdio_master pmr_mdio_master_i (.mdc_out(mdc), .line_out(line), .slave_oe_in(oe),
    .slave_data_in(data_out));

  // System clock and pulse counters.
  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (sublayer_reset_out === 1'b1) n_reset <= n_reset + 1;
    if (autoneg_restart_out === 1'b1) n_restart <= n_restart + 1;
  end

  task automatic report_and_stop();
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] phy, input logic [4:0] ra, input logic [15:0] exp);
    logic [15:0] v;
    pmr_mdio_master_i.frame(2'h2, phy, ra, 16'h0000, v);
    cmp(v, exp);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] v;
    pmr_mdio_master_i.frame(2'h1, own_addr, ra, d, v);
  endtask

  // Bounded run time.
  initial begin
    repeat (60000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end

  // Main sequence of management frames.
  initial begin
    rst_n_in = 1'b0;
    link_up_in = 1'b1;
    autoneg_done_in = 1'b1;
    slave_phys_addr_in = own_addr;
    pmr_mdio_master_i.idle(4);
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    pmr_mdio_master_i.idle(4);
    rd(own_addr, 5'h00, 16'h1140);
    rd(5'h00, 5'h00, 16'h1140);
    rd(5'h09, 5'h00, 16'hFFFF);
    for (int i = 0; i < 10; i++) begin
      rd(own_addr, dec_tab[i][20:16], dec_tab[i][15:0]);
    end
    @(negedge clk_in) link_up_in = 1'b0;
    rd(own_addr, 5'h01, 16'h01E8);
    @(negedge clk_in) {link_up_in, autoneg_done_in} = 2'b10;
    rd(own_addr, 5'h01, 16'h01CC);
    @(negedge clk_in) autoneg_done_in = 1'b1;
    wr(5'h00, 16'h643F);
    rd(own_addr, 5'h00, 16'h4560);
    cmp({11'h000, ctrl_out}, 16'h0013);
    wr(5'h00, 16'h0800);
    wr(5'h00, 16'h0000);
    rd(own_addr, 5'h00, 16'h0940);
    cmp({11'h000, ctrl_out}, 16'h0004);
    wr(5'h00, 16'h0200);
    rd(own_addr, 5'h00, 16'h0940);
    cmp(n_restart[15:0], 16'h0001);
    wr(5'h11, 16'hA5C3);
    rd(own_addr, 5'h11, 16'hA5C3);
    wr(5'h00, 16'h8000);
    rd(own_addr, 5'h00, 16'h1140);
    cmp(n_reset[15:0], 16'h0001);
    cmp({11'h000, ctrl_out}, 16'h0008);
    rd(own_addr, 5'h11, 16'h0000);
    report_and_stop();
  end
endmodule // pmr_mdio_regs_bench

//--- pmr_mdio_regs_checker.sv
/*
  Holds the concurrent checks on the ports of the management register block.
  Assumes it is bound to the register block and that the clocks stand still when idle.
*/
`timescale 1ns/1ps

module pmr_mdio_regs_checker
  import pmr_pkg::*;
#(
  parameter logic [4:0] ctrl_init = 5'h08
) (
  input wire logic               clk_in,
  input wire logic               rst_n_in,
  input wire logic               mgmt_clock_in,
  input wire logic               mdio_data_out,
  input wire logic               mdio_oe_out,
  input wire pmr_pkg::pmr_ctrl_t ctrl_out,
  input wire logic               sublayer_reset_out,
  input wire logic               autoneg_restart_out
);
  // Self-clearing control strobes last one cycle; the reset strobe reloads the start-up values.
  a_reset_pulse_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sublayer_reset_out |=> !sublayer_reset_out) else $error("reset pulse too long");
  a_restart_pulse_once: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    autoneg_restart_out |=> !autoneg_restart_out) else $error("restart pulse too long");
  a_reset_reloads_ctrl: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sublayer_reset_out |-> ##[0:2] (ctrl_out == ctrl_init)) else $error("reset did not reload");
  a_power_down_held: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(ctrl_out.power_down) |-> sublayer_reset_out || $past(sublayer_reset_out)
    || $past(sublayer_reset_out, 2)) else $error("power down cleared without reset");
  a_start_up_values: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in) |-> ##[0:4] (ctrl_out == ctrl_init)) else $error("start-up values wrong");
  // A read answer is a zero turnaround bit, sixteen data bits, then release.
  a_turn_drives_zero: assert property (@(posedge mgmt_clock_in) disable iff (!rst_n_in)
    $rose(mdio_oe_out) |-> !mdio_data_out) else $error("turnaround bit not zero");
  a_read_window_held: assert property (@(posedge mgmt_clock_in) disable iff (!rst_n_in)
    $rose(mdio_oe_out) |-> mdio_oe_out[*8] ##1 mdio_oe_out[*8] ##1 mdio_oe_out)
    else $error("read drive window too short");
  a_read_line_freed: assert property (@(posedge mgmt_clock_in) disable iff (!rst_n_in)
    $rose(mdio_oe_out) |-> ##17 !mdio_oe_out) else $error("line not released after read");
endmodule // pmr_mdio_regs_checker

bind pmr_mdio_regs pmr_mdio_regs_checker #(
  .ctrl_init({loopback_init_attr, autoneg_enable_init_attr, power_down_init_attr,
              isolate_init_attr, one_way_tx_init_attr})
) pmr_mdio_regs_checker_i (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .mgmt_clock_in(mgmt_clock_in),
  .mdio_data_out(mdio_data_out), .mdio_oe_out(mdio_oe_out), .ctrl_out(ctrl_out),
  .sublayer_reset_out(sublayer_reset_out), .autoneg_restart_out(autoneg_restart_out)
);

//--- pmr_pkg.sv
/*
  Holds the types shared by the management register block.
  Assumes the constants header is on the include path.
*/
package pmr_pkg;

  // Receive and transmit shifter phases of one management frame.
  typedef enum logic [2:0] {
    PMR_IDLE,
    PMR_HEADER,
    PMR_TURN,
    PMR_DATA_OUT,
    PMR_DATA_IN
  } pmr_phase_t;

  // One register write taken from the link.
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] data;
  } pmr_write_t;

  // Control requests toward the sublayer.
  typedef struct packed {
    logic loopback;
    logic autoneg_enable;
    logic power_down;
    logic isolate;
    logic one_way_tx;
  } pmr_ctrl_t;

endpackage
